// ===== logic/adc_pkg.sv
// Shared constants of the area 2 DRAM/SDRAM mode control block.
// Assumes a single system clock domain and an APB register port.
package adc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STAT_OFS   = 12'h004;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'hc8c3;

  // ==========================================================================
  // Control field positions
  // ==========================================================================
  localparam int BIT_DRAM_SEL  = 15;
  localparam int BIT_TYPE_SEL  = 14;
  localparam int BIT_CKE_EN    = 11;
  localparam int BIT_BURST     = 7;
  localparam int BIT_HOLD_LOW  = 6;
  localparam int BIT_SHIFT_HI  = 1;
  localparam int BIT_SHIFT_LO  = 0;

  // ==========================================================================
  // Status field positions
  // ==========================================================================
  localparam int STB_ROW_OPEN  = 0;
  localparam int STB_HELD      = 1;
  localparam int STB_BUSY      = 2;
  localparam int STB_KEY_LSB   = 16;

  // Row shift for multiplex encoding 00; each step of the field adds one.
  localparam logic [4:0] ROW_SHIFT_BASE = 5'h08;

  // ==========================================================================
  // Memory commands and controller states
  // ==========================================================================
  localparam logic [2:0] CMD_NOP       = 3'h0;
  localparam logic [2:0] CMD_ACTIVATE  = 3'h1;
  localparam logic [2:0] CMD_READ      = 3'h2;
  localparam logic [2:0] CMD_WRITE     = 3'h3;
  localparam logic [2:0] CMD_PRECHARGE = 3'h4;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACT  = 5'h02,
    ST_COL  = 5'h04,
    ST_OPEN = 5'h08,
    ST_PRE  = 5'h10
  } adc_state_t;

endpackage : adc_pkg

// ===== logic/adc_row_map.sv
// Row address multiplexing and page-hit key for area 2 accesses.
// Purely combinational; the caller registers whatever leaves the chip.
module adc_row_map import adc_pkg::*; #(
  parameter int ADDR_W     = 24,
  parameter int MEM_ADDR_W = 16
) (
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [1:0]            shift_sel_in,
  input  wire logic                  wide_in,
  output logic      [MEM_ADDR_W-1:0] row_addr_out,
  output logic      [ADDR_W-1:0]     row_key_out
);

  // ==========================================================================
  // Shift and compare range
  // ==========================================================================
  initial begin
    if (ADDR_W < 12 || MEM_ADDR_W > ADDR_W) begin
      $error("adc_row_map: unsupported address widths");
    end
  end

  wire [4:0]        row_shift = ROW_SHIFT_BASE + {3'h0, shift_sel_in};
  wire [4:0]        key_lsb   = row_shift + {4'h0, wide_in};
  wire [ADDR_W-1:0] shifted   = addr_in >> row_shift;
  wire [ADDR_W-1:0] key_mask  = {ADDR_W{1'b1}} << key_lsb;

  assign row_addr_out = shifted[MEM_ADDR_W-1:0];
  // A 16-bit space drops one more low bit from the compare.
  assign row_key_out  = addr_in & key_mask;

endmodule : adc_row_map

// ===== logic/adc_apb_regs.sv
// APB slave holding the area 2 control register and the status word.
// Assumes an APB master on the same clock; answers with no wait states.
module adc_apb_regs import adc_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [31:0] status_in,
  output logic      [15:0] ctrl_out,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire hit_ctrl = (paddr_in == CTRL_OFS);
  wire hit_stat = (paddr_in == STAT_OFS);
  wire mapped   = hit_ctrl | hit_stat;
  wire setup    = psel_in & ~penable_in;
  wire access   = psel_in & penable_in;
  wire wr_ctrl  = access & pwrite_in & hit_ctrl;

  wire [31:0] rd_value = hit_ctrl ? {16'h0000, ctrl_out} :
                         hit_stat ? status_in : 32'h0000_0000;
  wire [15:0] next_ctrl = wr_ctrl ? (pwdata_in[15:0] & CTRL_WMASK) : ctrl_out;

  assign pready_out  = 1'b1;
  assign pslverr_out = access & ~mapped;

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Read data is captured in the setup phase so it comes from a flop.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_out   <= CTRL_RESET;
      prdata_out <= 32'h0000_0000;
    end else begin
      ctrl_out   <= next_ctrl;
      prdata_out <= setup ? rd_value : prdata_out;
    end
  end

endmodule : adc_apb_regs

// ===== logic/adc_ctrl_top.sv
// Area 2 DRAM/SDRAM mode control: register port, row tracking and the
// command sequencer that drives the memory strobes of area 2.
// Assumes the access port comes from bus logic on the same clock and that
// a request is held until it is acknowledged.
//
// Summary of operation
// - Control bit 15 sends area 2 to SRAM interface (0) or DRAM/SDRAM (1).
// - Bit 14 picks conventional DRAM strobes (0) or SDRAM commands (1).
// - Bit 11 enables the SDRAM clock-enable output.
// - Bit 7: 0 closes the row after every access, 1 keeps page open.
// - Bit 6 keeps the row strobe low during other-area accesses when set.
// - The hold-low choice only acts while page mode is enabled.
// - Clearing hold-low while holding the row closes it and raises the strobe.
// - Same-row access in page mode issues read/write without an activate.
// - Bits 1:0 set the row shift; 00 shifts by eight bits.
// - Bits 1:0 also set compared row bits: 00 compares 23..8, or 23..9 for 16-bit spaces.
module adc_ctrl_top import adc_pkg::*; #(
  parameter int ADDR_W     = 24,
  parameter int MEM_ADDR_W = 16
) (
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  RESET_N_IN,
  input  wire logic                  PSEL_IN,
  input  wire logic                  PENABLE_IN,
  input  wire logic                  PWRITE_IN,
  input  wire logic [11:0]           PADDR_IN,
  input  wire logic [31:0]           PWDATA_IN,
  output logic      [31:0]           PRDATA_OUT,
  output logic                       PREADY_OUT,
  output logic                       PSLVERR_OUT,
  input  wire logic                  ACC_REQ_IN,
  input  wire logic                  ACC_AREA2_IN,
  input  wire logic                  ACC_WRITE_IN,
  input  wire logic                  ACC_WIDE_IN,
  input  wire logic [ADDR_W-1:0]     ACC_ADDR_IN,
  input  wire logic                  ACC_OTHER_IN,
  output logic                       ACC_SRAM_SEL_OUT,
  output logic                       ACC_ACK_OUT,
  output logic      [2:0]            SD_CMD_OUT,
  output logic                       RAS_N_OUT,
  output logic                       CAS_N_OUT,
  output logic                       CKE_OUT,
  output logic      [MEM_ADDR_W-1:0] MEM_ADDR_OUT
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  initial begin
    // The row address slice of the shift-by-eight encoding must fit the access address.
    if (ADDR_W < STB_KEY_LSB || MEM_ADDR_W + 8 > ADDR_W) begin
      $error("adc_ctrl_top: unsupported address widths");
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [15:0] ctrl;
  logic [31:0] status;

  adc_apb_regs u_regs (
    .clk_in      (CLK_SYS_IN),
    .rst_n_in    (RESET_N_IN),
    .psel_in     (PSEL_IN),
    .penable_in  (PENABLE_IN),
    .pwrite_in   (PWRITE_IN),
    .paddr_in    (PADDR_IN),
    .pwdata_in   (PWDATA_IN),
    .status_in   (status),
    .ctrl_out    (ctrl),
    .prdata_out  (PRDATA_OUT),
    .pready_out  (PREADY_OUT),
    .pslverr_out (PSLVERR_OUT)
  );

  wire area2_dram_interface_select = ctrl[BIT_DRAM_SEL];
  wire dram_type_select            = ctrl[BIT_TYPE_SEL];
  wire clock_enable_output_enable  = ctrl[BIT_CKE_EN];
  wire burst_page_enable           = ctrl[BIT_BURST];
  wire row_strobe_hold_low_mode    = ctrl[BIT_HOLD_LOW];
  wire row_shift_select_hi         = ctrl[BIT_SHIFT_HI];
  wire row_shift_select_lo         = ctrl[BIT_SHIFT_LO];

  // ==========================================================================
  // Row address and page-hit key
  // ==========================================================================
  logic [MEM_ADDR_W-1:0] row_addr;
  logic [ADDR_W-1:0]     row_key;

  adc_row_map #(
    .ADDR_W     (ADDR_W),
    .MEM_ADDR_W (MEM_ADDR_W)
  ) u_row_map (
    .addr_in      (ACC_ADDR_IN),
    .shift_sel_in ({row_shift_select_hi, row_shift_select_lo}),
    .wide_in      (ACC_WIDE_IN),
    .row_addr_out (row_addr),
    .row_key_out  (row_key)
  );

  // ==========================================================================
  // Sequencer state and decode
  // ==========================================================================
  adc_state_t            state;
  adc_state_t            next_state;
  logic [ADDR_W-1:0]     open_key;
  logic                  held;
  logic [2:0]            cmd;
  logic                  ras_n;
  logic                  cas_n;
  logic                  cke;
  logic [MEM_ADDR_W-1:0] mem_addr;

  wire area2_req = ACC_REQ_IN & ACC_AREA2_IN;
  wire dram_req  = area2_req & area2_dram_interface_select;
  wire row_hit   = (row_key == open_key);
  wire is_open   = (state == ST_OPEN);

  // An open page survives only in page mode; without hold-low it is closed
  // as soon as another area or an I/O register takes the bus.
  wire close_page = ~burst_page_enable | ~area2_dram_interface_select |
                    (~row_strobe_hold_low_mode & (ACC_OTHER_IN | held));

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (dram_req) begin
          next_state = ST_ACT;
        end
      end
      ST_ACT: begin
        next_state = ST_COL;
      end
      ST_COL: begin
        if (burst_page_enable && area2_dram_interface_select) begin
          next_state = ST_OPEN;
        end else begin
          next_state = ST_PRE;
        end
      end
      ST_OPEN: begin
        if (close_page) begin
          next_state = ST_PRE;
        end else if (dram_req && row_hit) begin
          next_state = ST_COL;
        end else if (dram_req) begin
          next_state = ST_PRE;
        end
      end
      ST_PRE: begin
        if (dram_req) begin
          next_state = ST_ACT;
        end else begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Next output values
  // ==========================================================================
  wire enter_act  = (next_state == ST_ACT);
  wire enter_col  = (next_state == ST_COL);
  wire enter_pre  = (next_state == ST_PRE);
  wire row_active = enter_act | enter_col | (next_state == ST_OPEN);
  wire [2:0] col_cmd = ACC_WRITE_IN ? CMD_WRITE : CMD_READ;

  // Conventional DRAM sees only the strobes; command codes are SDRAM only.
  wire [2:0] next_cmd = ~dram_type_select ? CMD_NOP :
                        enter_act ? CMD_ACTIVATE :
                        enter_col ? col_cmd :
                        enter_pre ? CMD_PRECHARGE : CMD_NOP;
  wire next_ras_n = ~row_active;
  wire next_cas_n = ~(enter_col & ~dram_type_select);
  wire next_cke   = clock_enable_output_enable & dram_type_select &
                    area2_dram_interface_select;
  wire [MEM_ADDR_W-1:0] next_mem_addr =
    enter_act ? row_addr :
    enter_col ? ACC_ADDR_IN[MEM_ADDR_W-1:0] : mem_addr;
  wire [ADDR_W-1:0] next_open_key = (state == ST_ACT) ? row_key : open_key;
  wire next_held = is_open & (ACC_OTHER_IN | held);

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state    <= ST_IDLE;
      open_key <= '0;
      held     <= 1'b0;
      cmd      <= CMD_NOP;
      ras_n    <= 1'b1;
      cas_n    <= 1'b1;
      cke      <= 1'b0;
      mem_addr <= '0;
    end else begin
      state    <= next_state;
      open_key <= next_open_key;
      held     <= next_held;
      cmd      <= next_cmd;
      ras_n    <= next_ras_n;
      cas_n    <= next_cas_n;
      cke      <= next_cke;
      mem_addr <= next_mem_addr;
    end
  end

  // ==========================================================================
  // Outputs and status
  // ==========================================================================
  assign ACC_SRAM_SEL_OUT = area2_req & ~area2_dram_interface_select;
  assign ACC_ACK_OUT      = (state == ST_COL);
  assign SD_CMD_OUT       = cmd;
  assign RAS_N_OUT        = ras_n;
  assign CAS_N_OUT        = cas_n;
  assign CKE_OUT          = cke;
  assign MEM_ADDR_OUT     = mem_addr;

  wire busy = ~(state == ST_IDLE) & ~is_open;
  assign status = {open_key[ADDR_W-1 -: 16], 13'h0000, busy, held, ~ras_n};

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_sram_no_act: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (state == ST_IDLE && !area2_dram_interface_select) |=> (state == ST_IDLE))
    else $error("activate started while area 2 is routed to SRAM");

  a_type_cmd_gate: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (SD_CMD_OUT != CMD_NOP) |-> ($past(dram_type_select) && CAS_N_OUT))
    else $error("SDRAM command issued in conventional DRAM mode");

  a_cke_follow: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    $rose(CKE_OUT) |-> $past(clock_enable_output_enable && dram_type_select))
    else $error("clock enable raised without its enable bit");

  a_full_close: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (state == ST_COL && !burst_page_enable) |=> (state == ST_PRE && RAS_N_OUT))
    else $error("full access did not close the row");

  a_up_mode_close: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (is_open && ACC_OTHER_IN && !row_strobe_hold_low_mode) |=> RAS_N_OUT)
    else $error("row strobe stayed low in up mode");

  a_hold_needs_burst: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (is_open && !burst_page_enable) |=> (state == ST_PRE && RAS_N_OUT))
    else $error("page held open without page mode");

  a_hold_cancel: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (is_open && held && !row_strobe_hold_low_mode) |=> RAS_N_OUT)
    else $error("clearing hold-low did not raise the row strobe");

  a_hit_no_activate: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (is_open && !close_page && dram_req && row_hit && dram_type_select)
      |=> (SD_CMD_OUT == CMD_READ || SD_CMD_OUT == CMD_WRITE) && !RAS_N_OUT)
    else $error("same-row access did not go straight to the column command");

  a_row_shift: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (state == ST_IDLE && dram_req && !row_shift_select_hi && !row_shift_select_lo)
      |=> (MEM_ADDR_OUT == $past(ACC_ADDR_IN[MEM_ADDR_W+7:8])))
    else $error("row address not shifted by eight bits");

  a_miss_reopen: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (is_open && !close_page && dram_req && !row_hit)
      |=> (state == ST_PRE) ##1 (state == ST_ACT) ##1 (state == ST_COL))
    else $error("row miss did not precharge and reactivate");

  a_ack_single: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    ACC_ACK_OUT |=> !ACC_ACK_OUT)
    else $error("access acknowledge lasted more than one cycle");

  a_idle_closed: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (state == ST_IDLE) |-> (RAS_N_OUT && CAS_N_OUT && SD_CMD_OUT == CMD_NOP))
    else $error("memory strobes active while the sequencer is idle");

  a_dram_cmd_nop: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    !dram_type_select |=> (SD_CMD_OUT == CMD_NOP))
    else $error("command code issued in conventional DRAM mode");

  a_sdram_no_cas: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    dram_type_select |=> CAS_N_OUT)
    else $error("column strobe pulsed in SDRAM mode");

  a_cke_off: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    !clock_enable_output_enable |=> !CKE_OUT)
    else $error("clock enable driven while its enable bit is clear");

  a_cke_on: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (clock_enable_output_enable && dram_type_select && area2_dram_interface_select) |=> CKE_OUT)
    else $error("clock enable not driven while enabled for SDRAM");

  a_page_stays: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (state == ST_COL && burst_page_enable && area2_dram_interface_select) |=> (is_open && !RAS_N_OUT))
    else $error("page mode did not keep the row open");

  a_down_keeps: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (is_open && !dram_req && ACC_OTHER_IN && row_strobe_hold_low_mode && burst_page_enable &&
     area2_dram_interface_select) |=> (is_open && !RAS_N_OUT))
    else $error("row strobe rose during another access in down mode");

  a_hit_no_activate_command: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (is_open && !close_page && dram_req && row_hit) |=> (state == ST_COL && SD_CMD_OUT != CMD_ACTIVATE))
    else $error("same-row access issued an activate");

  a_key_capture: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (state == ST_ACT) |=> (open_key == $past(row_key)))
    else $error("open row key not taken at activation");

  a_col_addr: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (state == ST_ACT) |=> (MEM_ADDR_OUT == $past(ACC_ADDR_IN[MEM_ADDR_W-1:0])))
    else $error("column address not driven after activation");

  a_pre_raises: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (state == ST_PRE) |-> RAS_N_OUT)
    else $error("row strobe low during precharge");

endmodule : adc_ctrl_top

// ===== test/adc_mem_model.sv
// Behavioural area 2 memory: tracks the open row and counts row and column cycles.
// Assumes registered strobes from the controller on the same clock.
module adc_mem_model import adc_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [2:0]  cmd_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic [15:0] addr_in,
  output logic      [15:0] act_n_out,
  output logic      [15:0] col_n_out,
  output logic      [15:0] row_out,
  output logic             err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Row and column tracking
  // ==========================================================================
  // A falling row strobe opens a row in both memory types, so one counter serves both.
  logic ras_q;
  wire  opening = ras_q & ~ras_n_in;
  wire  col_cmd = (cmd_in == CMD_READ) | (cmd_in == CMD_WRITE) | ~cas_n_in;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ras_q     <= 1'b1;
      act_n_out <= 16'h0000;
      col_n_out <= 16'h0000;
      row_out   <= 16'h0000;
      err_out   <= 1'b0;
    end else begin
      ras_q <= ras_n_in;
      if (opening) begin
        act_n_out <= act_n_out + 16'h0001;
        row_out   <= addr_in;
      end
      if (col_cmd) begin
        col_n_out <= col_n_out + 16'h0001;
      end
      // A column with no open row, or an activate onto an open row, is illegal.
      if ((col_cmd && ras_n_in) || (cmd_in == CMD_ACTIVATE && !ras_q)) begin
        err_out <= 1'b1;
      end
    end
  end
endmodule : adc_mem_model

// ===== test/adc_tb.sv
// Self-checking bench for the area 2 DRAM/SDRAM mode control block.
// Assumes adc_pkg, the design and adc_mem_model are compiled first.
module tb import adc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, psel, penable, pwrite, req, area2, wr, wide, other;
  logic        pready, pslverr, sram_sel, ack, ras_n, cas_n, cke, perr, sdram;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  sd_cmd;
  logic [15:0] mem_addr, act_n, col_n, row, a0;
  logic [23:0] addr;
  int          miscompares, n_compared, cycles;
  adc_ctrl_top adc_ctrl_top_inst (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ACC_REQ_IN(req),
    .ACC_AREA2_IN(area2), .ACC_WRITE_IN(wr), .ACC_WIDE_IN(wide), .ACC_ADDR_IN(addr),
    .ACC_OTHER_IN(other), .ACC_SRAM_SEL_OUT(sram_sel), .ACC_ACK_OUT(ack), .SD_CMD_OUT(sd_cmd),
    .RAS_N_OUT(ras_n), .CAS_N_OUT(cas_n), .CKE_OUT(cke), .MEM_ADDR_OUT(mem_addr));
  adc_mem_model adc_mem_model_inst (.clk_in(clk), .rst_n_in(rst_n), .cmd_in(sd_cmd),
    .ras_n_in(ras_n), .cas_n_in(cas_n), .addr_in(mem_addr), .act_n_out(act_n),
    .col_n_out(col_n), .row_out(row), .err_out(perr));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // The master holds the request until pready is seen high, then releases it.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1 && cycles < 20000);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wctl(input logic [15:0] d);
    logic e;
    apb(1'b1, CTRL_OFS, {16'h0000, d}, e);
  endtask : wctl
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    logic e;
    apb(1'b0, a, 32'h0000_0000, e);
    chk(rd, exp);
    chk(e, eerr);
  endtask : rchk
  // Counts rising edges from the request until the acknowledge is sampled high.
  task automatic acc(input logic [23:0] a, input logic w16, input int exp_n);
    int n;
    @(posedge clk);
    req   <= 1'b1;
    area2 <= 1'b1;
    wr    <= a[0];
    wide  <= w16;
    addr  <= a;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk(n, exp_n);
    chk(sd_cmd, sdram ? (a[0] ? CMD_WRITE : CMD_READ) : CMD_NOP);
    chk(cas_n, sdram);
    chk(mem_addr, a[15:0]);
    req <= 1'b0;
  endtask : acc
  task automatic pulse_other(input int n, input logic exp_ras);
    @(posedge clk);
    other <= 1'b1;
    repeat (n) @(posedge clk);
    chk(ras_n, exp_ras);
    other <= 1'b0;
  endtask : pulse_other
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs;
    chk({sd_cmd, ras_n, cas_n, cke}, 6'h06);
    rchk(CTRL_OFS, 32'h0000_0000, 1'b0);
    wctl(16'hffff);
    rchk(CTRL_OFS, 32'h0000_c8c3, 1'b0);
    rchk(12'h008, 32'h0000_0000, 1'b1);
  endtask : t_regs
  task automatic t_sram;
    wctl(16'h4000);
    @(posedge clk);
    req   <= 1'b1;
    area2 <= 1'b1;
    repeat (5) @(negedge clk);
    chk({sram_sel, ack}, 2'h2);
    @(posedge clk);
    req <= 1'b0;
  endtask : t_sram
  task automatic t_cke;
    logic [15:0] v [4] = '{16'hc800, 16'h8800, 16'hc000, 16'h4800};
    for (int i = 0; i < 4; i++) begin
      wctl(v[i]);
      repeat (2) @(posedge clk);
      chk(cke, i == 0);
    end
  endtask : t_cke
  task automatic t_full;
    wctl(16'hc000);
    a0 = act_n;
    acc(24'h123456, 1'b0, 3);
    acc(24'h123457, 1'b0, 3);
    repeat (2) @(posedge clk);
    chk(act_n, a0 + 16'h0002);
    chk(ras_n, 1'b1);
    sdram = 1'b0;
    wctl(16'h8000);
    a0 = col_n;
    acc(24'h000040, 1'b0, 3);
    @(posedge clk);
    chk(col_n, a0 + 16'h0001);
    sdram = 1'b1;
  endtask : t_full
  task automatic t_shift;
    for (int f = 0; f < 4; f++) begin
      wctl(16'hc000 | 16'(f));
      acc(24'habcdef, 1'b0, 3);
      chk(row, 16'(24'habcdef >> (8 + f)));
    end
  endtask : t_shift
  task automatic t_page;
    wctl(16'hc080);
    a0 = act_n;
    acc(24'h000100, 1'b0, 3);
    rchk(STAT_OFS, 32'h0001_0001, 1'b0);
    acc(24'h000181, 1'b0, 2);
    acc(24'h000000, 1'b0, 4);
    chk(act_n, a0 + 16'h0002);
    pulse_other(2, 1'b1);
    acc(24'h000300, 1'b1, 3);
    acc(24'h000200, 1'b1, 2);
    pulse_other(2, 1'b1);
  endtask : t_page
  task automatic t_hold;
    wctl(16'hc0c0);
    acc(24'h001000, 1'b0, 3);
    a0 = act_n;
    pulse_other(4, 1'b0);
    acc(24'h001005, 1'b0, 2);
    chk(act_n, a0);
    @(posedge clk);
    other <= 1'b1;
    wctl(16'hc080);
    repeat (2) @(posedge clk);
    chk(ras_n, 1'b1);
    other <= 1'b0;
    wctl(16'hc040);
    acc(24'h002000, 1'b0, 3);
    pulse_other(2, 1'b1);
    chk(perr, 1'b0);
  endtask : t_hold
  // ==========================================================================
  // Clock, reset, timeout and main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    {psel, penable, pwrite, req, area2, wr, wide, other} = 8'h00;
    paddr  = 12'h000;
    pwdata = 32'h0000_0000;
    addr   = 24'h000000;
    sdram  = 1'b1;
    rst_n  = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_sram();
    t_cke();
    t_full();
    t_shift();
    t_page();
    t_hold();
    wrap_up();
  end
endmodule : tb
